/* File: verif/touch_event_recal_config_tb.sv */
`timescale 1ns/1ps
module touch_event_recal_config_tb;
  logic                          clk_in = 1'b0;
  logic                          sys_rst_in = 1'b1;
  logic                          ce = 1'b1;
  touch_event_pkg::axil_req_type req;
  touch_event_pkg::axil_rsp_type rsp;
  logic [7:0]                    touch = 8'h00;
  logic [7:0]                    ph = 8'h00;
  logic                          rt = 1'b0;
  logic                          pt = 1'b0;
  logic [7:0]                    nd = 8'h00;
  logic                          irq;
  logic [7:0]                    recal;
  logic                          base;
  logic [55:0]                   thr;
  logic [31:0]                   v;
  logic [1:0]                    r;
  int                            err_count = 0;
  int                            total_checks = 0;
  int                            cycles = 0;
  int                            nrecal = 0;
  int                            nbase = 0;

  always #12.5 clk_in = ~clk_in;

  touch_event_recal_config i_touch_event_recal_config (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce), .axil_req_in(req), .axil_rsp_out(rsp),
    .touch_raw_in(touch), .press_hold_in(ph), .repeat_tick_in(rt), .poll_tick_in(pt),
    .negative_delta_in(nd), .irq_out(irq), .recal_req_out(recal), .sample_window_out(),
    .baseline_load_out(base), .thresholds_out(thr));

  touch_host_model i_touch_host_model (.clk_in(clk_in), .axil_req_out(req), .axil_rsp_in(rsp));

  // ----------------------------------------------------------------------
  // Watchdog and pulse counters
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      final_report();
    end
  end

  always @(negedge clk_in) begin
    if (recal[0] === 1'b1) nrecal++;
    if (base === 1'b1) nbase++;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    i_touch_host_model.wr(ix, d, r);
  endtask

  task automatic rdc(input string nm, input logic [7:0] ix, input logic [7:0] e);
    i_touch_host_model.rd(ix, v, r);
    chk(nm, {24'h0, e}, v);
  endtask

  // Touch inputs move right after an edge; events settle within three edges.
  task automatic go(input logic [7:0] t, input logic [7:0] p);
    @(posedge clk_in);
    touch <= t;
    ph <= p;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic tick(input bit poll);
    @(posedge clk_in);
    if (poll) pt <= 1'b1;
    else rt <= 1'b1;
    @(posedge clk_in);
    pt <= 1'b0;
    rt <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rdc("irq_enable", 8'h27, 8'hFF);
    rdc("repeat_enable", 8'h28, 8'hFF);
    rdc("multi_cfg", 8'h2A, 8'h80);
    rdc("recal_cfg", 8'h2F, 8'h8B);
    i_touch_host_model.rd(8'h3F, v, r);
    chk("unmapped_resp", 56'h3, {54'h0, r});
    chk("thresholds", {8{7'h40}}, thr);
    $display("test reset done");
  endtask

  task automatic t_irq();
    @(posedge clk_in);
    ce <= 1'b0;
    go(8'h01, 8'h00);
    chk("irq_frozen", 56'h0, irq);
    @(posedge clk_in);
    ce <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("irq_touch", 56'h1, irq);
    wr(8'h10, 8'hFF);
    chk("irq_cleared", 56'h0, irq);
    go(8'h00, 8'h00);
    chk("irq_release", 56'h1, irq);
    wr(8'h10, 8'hFF);
    wr(8'h27, 8'hFE);
    go(8'h01, 8'h00);
    chk("irq_masked", 56'h0, irq);
    go(8'h00, 8'h00);
    wr(8'h27, 8'hFF);
    $display("test irq done");
  endtask

  task automatic t_repeat();
    go(8'h01, 8'h01);
    wr(8'h10, 8'hFF);
    tick(1'b0);
    go(8'h01, 8'h01);
    chk("irq_repeat", 56'h1, irq);
    wr(8'h10, 8'hFF);
    go(8'h00, 8'h00);
    chk("irq_hold_release", 56'h0, irq);
    wr(8'h28, 8'h00);
    go(8'h01, 8'h00);
    wr(8'h10, 8'hFF);
    go(8'h01, 8'h01);
    tick(1'b0);
    go(8'h01, 8'h01);
    chk("irq_norepeat", 56'h0, irq);
    go(8'h00, 8'h00);
    chk("irq_norepeat_release", 56'h1, irq);
    wr(8'h10, 8'hFF);
    wr(8'h28, 8'hFF);
    $display("test repeat done");
  endtask

  task automatic t_block();
    go(8'h03, 8'h00);
    rdc("accepted_1", 8'h12, 8'h01);
    rdc("multi_flag", 8'h11, 8'h01);
    rdc("pending_1", 8'h10, 8'h01);
    go(8'h00, 8'h00);
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'hFF);
    wr(8'h2A, 8'h84);
    go(8'h07, 8'h00);
    rdc("accepted_2", 8'h12, 8'h03);
    go(8'h00, 8'h00);
    wr(8'h2A, 8'h00);
    wr(8'h10, 8'hFF);
    go(8'h07, 8'h00);
    rdc("pending_all", 8'h10, 8'h07);
    go(8'h00, 8'h00);
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'hFF);
    $display("test block done");
  endtask

  task automatic t_thresh();
    wr(8'h30, 8'h12);
    chk("thr_all", {8{7'h12}}, thr);
    wr(8'h31, 8'h05);
    chk("thr_two", {{6{7'h12}}, 7'h05, 7'h12}, thr);
    wr(8'h2F, 8'h0B);
    wr(8'h30, 8'h22);
    chk("thr_one", {{6{7'h12}}, 7'h05, 7'h22}, thr);
    $display("test thresholds done");
  endtask

  task automatic t_recal();
    wr(8'h2F, 8'h08);
    @(posedge clk_in);
    nd <= 8'h01;
    repeat (15) tick(1'b1);
    go(8'h00, 8'h00);
    chk("recal_early", 56'h0, nrecal);
    chk("base_early", 56'h0, nbase);
    tick(1'b1);
    go(8'h00, 8'h00);
    chk("recal_16", 56'h1, nrecal);
    chk("base_16", 56'h1, nbase);
    wr(8'h2F, 8'h18);
    repeat (32) tick(1'b1);
    go(8'h00, 8'h00);
    chk("recal_off", 56'h1, nrecal);
    chk("base_48", 56'h3, nbase);
    $display("test recalibration done");
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_irq();
    t_repeat();
    t_block();
    t_thresh();
    t_recal();
    final_report();
  end
endmodule

/* File: verif/touch_host_model.sv */
`timescale 1ns/1ps
module touch_host_model (
  // Clock
  input  wire logic                          clk_in,
  // Register bus
  output touch_event_pkg::axil_req_type      axil_req_out,
  input  wire touch_event_pkg::axil_rsp_type axil_rsp_in
);
  initial axil_req_out = '0;

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  // Each channel is judged at the rising edge itself, so a request never leaves before its ready.
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, output logic [1:0] rs);
    logic a;
    logic w;
    logic b;
    a = 1'b1;
    w = 1'b1;
    b = 1'b0;
    rs = 2'h0;
    @(posedge clk_in);
    axil_req_out.awaddr <= {ix[5:0], 2'h0};
    axil_req_out.wdata <= {24'h0, d};
    axil_req_out.wstrb <= 4'hF;
    axil_req_out.awvalid <= 1'b1;
    axil_req_out.wvalid <= 1'b1;
    axil_req_out.bready <= 1'b1;
    while (!b) begin
      @(posedge clk_in);
      if (a && axil_rsp_in.awready) begin
        a = 1'b0;
        axil_req_out.awvalid <= 1'b0;
      end
      if (w && axil_rsp_in.wready) begin
        w = 1'b0;
        axil_req_out.wvalid <= 1'b0;
      end
      if (axil_rsp_in.bvalid) begin
        b = 1'b1;
        rs = axil_rsp_in.bresp;
      end
    end
    axil_req_out.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ix, output logic [31:0] d, output logic [1:0] rs);
    logic a;
    logic b;
    a = 1'b1;
    b = 1'b0;
    d = 32'h0;
    rs = 2'h0;
    @(posedge clk_in);
    axil_req_out.araddr <= {ix[5:0], 2'h0};
    axil_req_out.arvalid <= 1'b1;
    axil_req_out.rready <= 1'b1;
    while (!b) begin
      @(posedge clk_in);
      if (a && axil_rsp_in.arready) begin
        a = 1'b0;
        axil_req_out.arvalid <= 1'b0;
      end
      if (axil_rsp_in.rvalid) begin
        b = 1'b1;
        d = axil_rsp_in.rdata;
        rs = axil_rsp_in.rresp;
      end
    end
    axil_req_out.rready <= 1'b0;
  endtask
endmodule

/* File: verilog/touch_event_defs.svh */
`ifndef TOUCH_EVENT_DEFS_SVH
`define TOUCH_EVENT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_INT_ENABLE     8'h27
`define IDX_REPEAT_ENABLE  8'h28
`define IDX_MULTI_TOUCH    8'h2A
`define IDX_RECAL_CONFIG   8'h2F
`define IDX_THRESHOLD_1    8'h30
`define IDX_THRESHOLD_8    8'h37
`define IDX_EVENT_PENDING  8'h10
`define IDX_MULTI_STATUS   8'h11
`define IDX_ACCEPTED       8'h12

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_INT_ENABLE     8'hFF
`define RST_REPEAT_ENABLE  8'hFF
`define RST_MULTI_TOUCH    8'h80
`define RST_RECAL_CONFIG   8'h8B
`define RST_THRESHOLD      7'h40

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_BLOCK_ENABLE   7
`define LIM_MSB            3
`define LIM_LSB            2
`define BIT_LOAD_ALL       7
`define NEG_MSB            4
`define NEG_LSB            3
`define CAL_MSB            2
`define CAL_LSB            0

// ----------------------------------------------------------------------------
// Counts in sensor polling periods
// ----------------------------------------------------------------------------
`define NEG_COUNT_8        6'd8
`define NEG_COUNT_16       6'd16
`define NEG_COUNT_32       6'd32
`define CAL_SAMPLES_256    13'd256
`define CAL_UPD_1024       13'd1024
`define CAL_UPD_2048       13'd2048
`define CAL_UPD_4096       13'd4096
`define CAL_UPD_7936       13'd7936

`endif

/* File: verilog/touch_event_pkg.sv */
package touch_event_pkg;

  // --------------------------------------------------------------------------
  // AXI4-Lite carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_type;

endpackage

/* File: verilog/touch_event_recal_config.sv */
`timescale 1ns/1ps
`include "touch_event_defs.svh"
// Behaviour
// - Per-input interrupt enable bits, all set at reset, gate touch and release events.
// - Cleared enable bit means touches on that input never assert the interrupt.
// - Per-input repeat enable bits, all set at reset.
// - Repeat disabled: one event at touch, one at release, regardless of duration.
// - Repeat enabled, short touch: event at touch and event at release.
// - Repeat enabled, press-and-hold: event at touch, then at each repeat interval.
// - Repeat enabled, press-and-hold: no event when the release comes.
// - Clearing the block enable bit reports every simultaneous touch.
// - Blocking on: accept touches up to the limit, block any beyond.
// - Accepted inputs are remembered; others stay blocked until those release.
// - Limit field decodes to one through four touches; exceeding flags a multi-touch event.
// - Load-all bit set: writing threshold one writes all eight thresholds.
// - Load-all bit clear: each threshold changes only by its own write.
// - Thresholds two through eight are always individually writable.
// - Negative delta trigger count field: 8, 16, 32 or disabled.
// - Calibration field selects recalibration samples and update time.
// - The calibration selection is shared by all inputs.
// - Update time counts polling periods; baseline loads after it elapses.
// - Update time longer than the samples: the sample window closes after the samples; the baseline then waits until the update time elapses.
module touch_event_recal_config #(
  parameter int NEG_CNT_W = 6
) (
  // Clock, reset, enable
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          ce_in,
  // Register bus
  input  wire touch_event_pkg::axil_req_type axil_req_in,
  output touch_event_pkg::axil_rsp_type      axil_rsp_out,
  // Sensing front end
  input  wire logic [7:0]                    touch_raw_in,
  input  wire logic [7:0]                    press_hold_in,
  input  wire logic                          repeat_tick_in,
  input  wire logic                          poll_tick_in,
  input  wire logic [7:0]                    negative_delta_in,
  // Results
  output logic                               irq_out,
  output logic [7:0]                         recal_req_out,
  output logic                               sample_window_out,
  output logic                               baseline_load_out,
  output logic [55:0]                        thresholds_out
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                  input_irq_enable;
    logic [7:0]                  input_repeat_enable;
    logic [7:0]                  multi_cfg;
    logic [7:0]                  recal_cfg;
    logic [7:0][6:0]             thr;
    logic [7:0]                  accepted;
    logic [7:0]                  held;
    logic [7:0]                  pending;
    logic                        multi_flag;
    logic [7:0][NEG_CNT_W-1:0]   neg_cnt;
    logic [7:0]                  recal_req;
    logic [12:0]                 poll_cnt;
    logic                        baseline_load;
    logic                        aw_held;
    logic [7:0]                  aw_addr;
    logic                        w_held;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } state_type;

  state_type s_q;
  state_type s_d;

  if (NEG_CNT_W < 6) begin : g_bad_width
    $error("NEG_CNT_W must hold a count of 32");
  end

  function automatic logic [3:0] popcount(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  // --------------------------------------------------------------------------
  // Decodes
  // --------------------------------------------------------------------------
  logic                 blk_en;
  logic [3:0]           touch_limit;
  logic                 load_all;
  logic [NEG_CNT_W-1:0] neg_target;
  logic                 neg_off;
  logic [12:0]          cal_samples;
  logic [12:0]          cal_update;

  always_comb begin
    blk_en      = s_q.multi_cfg[`BIT_BLOCK_ENABLE];
    touch_limit = {2'h0, s_q.multi_cfg[`LIM_MSB:`LIM_LSB]} + 4'h1;
    load_all    = s_q.recal_cfg[`BIT_LOAD_ALL];
    neg_off     = 1'b0;
    unique case (s_q.recal_cfg[`NEG_MSB:`NEG_LSB])
      2'h0: neg_target = NEG_CNT_W'(`NEG_COUNT_8);
      2'h1: neg_target = NEG_CNT_W'(`NEG_COUNT_16);
      2'h2: neg_target = NEG_CNT_W'(`NEG_COUNT_32);
      2'h3: begin
        neg_target = NEG_CNT_W'(`NEG_COUNT_32);
        neg_off    = 1'b1;
      end
    endcase
    cal_samples = `CAL_SAMPLES_256;
    unique case (s_q.recal_cfg[`CAL_MSB:`CAL_LSB])
      3'h0: begin
        cal_samples = 13'd16;
        cal_update  = 13'd16;
      end
      3'h1: begin
        cal_samples = 13'd32;
        cal_update  = 13'd32;
      end
      3'h2: begin
        cal_samples = 13'd64;
        cal_update  = 13'd64;
      end
      3'h3: cal_update = `CAL_SAMPLES_256;
      3'h4: cal_update = `CAL_UPD_1024;
      3'h5: cal_update = `CAL_UPD_2048;
      3'h6: cal_update = `CAL_UPD_4096;
      3'h7: cal_update = `CAL_UPD_7936;
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  logic       aw_fire;
  logic       w_fire;
  logic       ar_fire;
  logic       wr_go;
  logic [7:0] wr_addr;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic       wr_lane;
  logic [7:0] rd_idx;

  always_comb begin
    axil_rsp_out.awready = !s_q.aw_held && !s_q.bvalid;
    axil_rsp_out.wready  = !s_q.w_held && !s_q.bvalid;
    axil_rsp_out.arready = !s_q.rvalid;
    axil_rsp_out.bvalid  = s_q.bvalid;
    axil_rsp_out.bresp   = s_q.bresp;
    axil_rsp_out.rvalid  = s_q.rvalid;
    axil_rsp_out.rdata   = s_q.rdata;
    axil_rsp_out.rresp   = s_q.rresp;
    aw_fire = axil_req_in.awvalid && axil_rsp_out.awready;
    w_fire  = axil_req_in.wvalid && axil_rsp_out.wready;
    ar_fire = axil_req_in.arvalid && axil_rsp_out.arready;
    wr_go   = (s_q.aw_held || aw_fire) && (s_q.w_held || w_fire);
    wr_addr = s_q.aw_held ? s_q.aw_addr : axil_req_in.awaddr;
    wr_byte = s_q.w_held ? s_q.w_data[7:0] : axil_req_in.wdata[7:0];
    wr_lane = s_q.w_held ? s_q.w_strb[0] : axil_req_in.wstrb[0];
    wr_idx  = {2'h0, wr_addr[7:2]};
    rd_idx  = {2'h0, axil_req_in.araddr[7:2]};
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic [7:0] accept_d;
  logic [7:0] ev_set;
  logic [7:0] w1c_pend;
  logic       w1c_multi;
  logic       wr_ok;
  logic       rd_ok;
  logic [7:0] rd_byte;
  logic [3:0] n_acc;

  always_comb begin
    s_d       = s_q;
    accept_d  = 8'h00;
    ev_set    = 8'h00;
    w1c_pend  = 8'h00;
    w1c_multi = 1'b0;
    wr_ok     = 1'b0;
    rd_ok     = 1'b1;
    rd_byte   = 8'h00;
    n_acc     = 4'h0;

    // Touch acceptance: accepted inputs persist, newcomers fill free slots.
    for (int i = 0; i < 8; i++) begin
      accept_d[i] = touch_raw_in[i] && s_q.accepted[i];
    end
    n_acc = popcount(accept_d);
    for (int i = 0; i < 8; i++) begin
      if (touch_raw_in[i] && !accept_d[i] && (!blk_en || n_acc < touch_limit)) begin
        accept_d[i] = 1'b1;
        n_acc       = n_acc + 4'h1;
      end
    end
    s_d.accepted = accept_d;
    if (blk_en && popcount(touch_raw_in) > touch_limit) begin
      s_d.multi_flag = 1'b1;
    end

    // Event generation per input.
    for (int i = 0; i < 8; i++) begin
      if (accept_d[i] && !s_q.accepted[i]) begin
        ev_set[i] = 1'b1;
        s_d.held[i] = 1'b0;
      end else if (accept_d[i] && s_q.input_repeat_enable[i] && press_hold_in[i]) begin
        s_d.held[i] = 1'b1;
        ev_set[i]   = repeat_tick_in;
      end else if (!accept_d[i] && s_q.accepted[i]) begin
        ev_set[i]   = !(s_q.held[i] && s_q.input_repeat_enable[i]);
        s_d.held[i] = 1'b0;
      end
    end
    ev_set = ev_set & s_q.input_irq_enable;

    // Negative delta trigger per input.
    s_d.recal_req = 8'h00;
    if (poll_tick_in) begin
      for (int i = 0; i < 8; i++) begin
        if (!negative_delta_in[i] || neg_off) begin
          s_d.neg_cnt[i] = '0;
        end else if (s_q.neg_cnt[i] + 1'b1 >= neg_target) begin
          s_d.neg_cnt[i]   = '0;
          s_d.recal_req[i] = 1'b1;
        end else begin
          s_d.neg_cnt[i] = s_q.neg_cnt[i] + 1'b1;
        end
      end
    end

    // One shared update timer for all inputs; the baseline loads only at its end.
    s_d.baseline_load = 1'b0;
    if (poll_tick_in) begin
      if (s_q.poll_cnt + 13'd1 >= cal_update) begin
        s_d.poll_cnt      = 13'd0;
        s_d.baseline_load = 1'b1;
      end else begin
        s_d.poll_cnt = s_q.poll_cnt + 13'd1;
      end
    end

    // Write channel.
    if (aw_fire) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = axil_req_in.awaddr;
    end
    if (w_fire) begin
      s_d.w_held = 1'b1;
      s_d.w_data = axil_req_in.wdata;
      s_d.w_strb = axil_req_in.wstrb;
    end
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      wr_ok       = 1'b1;
      unique case (wr_idx)
        `IDX_INT_ENABLE: begin
          if (wr_lane) s_d.input_irq_enable = wr_byte;
        end
        `IDX_REPEAT_ENABLE: begin
          if (wr_lane) s_d.input_repeat_enable = wr_byte;
        end
        `IDX_MULTI_TOUCH: begin
          if (wr_lane) s_d.multi_cfg = wr_byte & 8'h8C;
        end
        `IDX_RECAL_CONFIG: begin
          if (wr_lane) s_d.recal_cfg = wr_byte & 8'h9F;
        end
        `IDX_EVENT_PENDING: begin
          if (wr_lane) w1c_pend = wr_byte;
        end
        `IDX_MULTI_STATUS: begin
          w1c_multi = wr_lane && wr_byte[0];
        end
        `IDX_ACCEPTED: begin
        end
        default: begin
          if (wr_idx >= `IDX_THRESHOLD_1 && wr_idx <= `IDX_THRESHOLD_8) begin
            if (wr_lane) begin
              if (wr_idx == `IDX_THRESHOLD_1 && load_all) begin
                for (int i = 0; i < 8; i++) s_d.thr[i] = wr_byte[6:0];
              end else begin
                s_d.thr[wr_idx[2:0]] = wr_byte[6:0];
              end
            end
          end else begin
            wr_ok = 1'b0;
          end
        end
      endcase
      s_d.bresp = wr_ok ? 2'h0 : 2'h3;
    end else if (s_q.bvalid && axil_req_in.bready) begin
      s_d.bvalid = 1'b0;
    end

    // Sticky flags: a new event wins over a clear in the same cycle.
    s_d.pending = (s_q.pending & ~w1c_pend) | ev_set;
    if (w1c_multi && !(blk_en && popcount(touch_raw_in) > touch_limit)) begin
      s_d.multi_flag = 1'b0;
    end

    // Read channel.
    if (ar_fire) begin
      unique case (rd_idx)
        `IDX_INT_ENABLE:    rd_byte = s_q.input_irq_enable;
        `IDX_REPEAT_ENABLE: rd_byte = s_q.input_repeat_enable;
        `IDX_MULTI_TOUCH:   rd_byte = s_q.multi_cfg;
        `IDX_RECAL_CONFIG:  rd_byte = s_q.recal_cfg;
        `IDX_EVENT_PENDING: rd_byte = s_q.pending;
        `IDX_MULTI_STATUS:  rd_byte = {7'h00, s_q.multi_flag};
        `IDX_ACCEPTED:      rd_byte = s_q.accepted;
        default: begin
          if (rd_idx >= `IDX_THRESHOLD_1 && rd_idx <= `IDX_THRESHOLD_8) begin
            rd_byte = {1'b0, s_q.thr[rd_idx[2:0]]};
          end else begin
            rd_ok = 1'b0;
          end
        end
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h000000, rd_byte};
      s_d.rresp  = rd_ok ? 2'h0 : 2'h3;
    end else if (s_q.rvalid && axil_req_in.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q                     <= '0;
      s_q.input_irq_enable    <= `RST_INT_ENABLE;
      s_q.input_repeat_enable <= `RST_REPEAT_ENABLE;
      s_q.multi_cfg           <= `RST_MULTI_TOUCH;
      s_q.recal_cfg           <= `RST_RECAL_CONFIG;
      for (int i = 0; i < 8; i++) s_q.thr[i] <= `RST_THRESHOLD;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    irq_out           = |s_q.pending;
    recal_req_out     = s_q.recal_req;
    baseline_load_out = s_q.baseline_load;
    sample_window_out = s_q.poll_cnt < cal_samples;
    thresholds_out    = s_q.thr;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_irq_or;
    @(posedge clk_in) disable iff (sys_rst_in)
      $rose(irq_out) |-> $past(ce_in && (ev_set != 8'h00));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq rose without an event");

  property p_touch_irq;
    @(posedge clk_in) disable iff (sys_rst_in)
      (ce_in && (ev_set != 8'h00)) |=> irq_out;
  endproperty
  a_touch_irq: assert property (p_touch_irq) else $error("enabled event did not raise irq");

  property p_masked;
    @(posedge clk_in) disable iff (sys_rst_in)
      ce_in |=> ((s_q.pending & ~$past(s_q.pending) & ~$past(s_q.input_irq_enable)) == 8'h00);
  endproperty
  a_masked: assert property (p_masked) else $error("masked input set pending");

  property p_no_hold_release;
    @(posedge clk_in) disable iff (sys_rst_in)
      (ce_in && touch_raw_in == 8'h00 && s_q.accepted == s_q.held
       && s_q.input_repeat_enable == 8'hFF && s_q.pending == 8'h00) |=> !irq_out;
  endproperty
  a_no_hold_release: assert property (p_no_hold_release) else $error("held release raised irq");

  property p_limit;
    @(posedge clk_in) disable iff (sys_rst_in)
      (blk_en && $stable(s_q.multi_cfg) && $past(popcount(s_q.accepted)) <= touch_limit)
      |-> popcount(s_q.accepted) <= touch_limit;
  endproperty
  a_limit: assert property (p_limit) else $error("accepted touches exceed limit");

  property p_load_all;
    @(posedge clk_in) disable iff (sys_rst_in)
      (ce_in && wr_go && wr_lane && wr_idx == `IDX_THRESHOLD_1 && load_all)
      |=> s_q.thr[7] == $past(wr_byte[6:0]);
  endproperty
  a_load_all: assert property (p_load_all) else $error("load-all missed threshold 8");

  property p_single;
    @(posedge clk_in) disable iff (sys_rst_in)
      (ce_in && wr_go && wr_idx == `IDX_THRESHOLD_1 && !load_all)
      |=> s_q.thr[1] == $past(s_q.thr[1]);
  endproperty
  a_single: assert property (p_single) else $error("threshold 2 changed by other write");

  property p_neg_bound;
    @(posedge clk_in) disable iff (sys_rst_in) s_q.neg_cnt[0] < NEG_CNT_W'(`NEG_COUNT_32);
  endproperty
  a_neg_bound: assert property (p_neg_bound) else $error("negative delta count overran");

  property p_load_tick;
    @(posedge clk_in) disable iff (sys_rst_in)
      baseline_load_out |-> $past(poll_tick_in) && s_q.poll_cnt == 13'd0;
  endproperty
  a_load_tick: assert property (p_load_tick) else $error("baseline load without timer end");

  property p_bhold;
    @(posedge clk_in) disable iff (sys_rst_in)
      (s_q.bvalid && !axil_req_in.bready) |=> s_q.bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");

  c_write: cover property (@(posedge clk_in) wr_go);
  c_read: cover property (@(posedge clk_in) ar_fire);
  c_repeat: cover property (@(posedge clk_in) ev_set != 8'h00 && repeat_tick_in && s_q.held != 8'h00);
  c_multi: cover property (@(posedge clk_in) s_q.multi_flag);

endmodule
